// >>> dv/dwdt_apb_host.sv
// Processor-side bus model that programs the watchdog registers.
`timescale 1ns/100ps
`default_nettype none

module dwdt_apb_host (
    input  wire logic        clk_in,
    input  wire logic [31:0] prdata_in,
    input  wire logic        pready_in,
    input  wire logic        pslverr_in,
    output logic             psel_out,
    output logic             penable_out,
    output logic             pwrite_out,
    output logic      [7:0]  paddr_out,
    output logic      [31:0] pwdata_out
);
    // Idle bus from time zero.
    initial begin
        psel_out = 1'b0;
        penable_out = 1'b0;
        pwrite_out = 1'b0;
        paddr_out = 8'h00;
        pwdata_out = 32'h00000000;
    end

    // Setup, access until ready, then release; address and data turn
    // to their inverse so a stale value can never pass for a live one.
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
                        output logic [31:0] q, output logic err);
        @(negedge clk_in);
        psel_out = 1'b1;
        pwrite_out = wr;
        paddr_out = a;
        pwdata_out = d;
        @(negedge clk_in);
        penable_out = 1'b1;
        @(posedge clk_in);
        for (int n = 0; n < 16 && pready_in !== 1'b1; n++) begin
            @(posedge clk_in);
        end
        q = prdata_in;
        err = pslverr_in;
        if (pready_in !== 1'b1) begin
            $display("ERROR %0t: bus ready never came", $time);
            tb_top.error_cnt++;
            tb_top.give_verdict();
        end
        @(negedge clk_in);
        psel_out = 1'b0;
        penable_out = 1'b0;
        paddr_out = ~a;
        pwdata_out = ~d;
    endtask
endmodule
`default_nettype wire

// >>> dv/dwdt_props.sv
// Port-level checker for the dual watchdog timer.
`timescale 1ns/100ps
`default_nettype none

module dwdt_props #(
    parameter int SW_DIV = 4
) (
    input wire logic        core_clk_in,
    input wire logic        nrst_in,
    input wire logic        soft_reset_in,
    input wire logic        pclk_halt_in,
    input wire logic        slow_rc_clock_in,
    input wire logic        psel_in,
    input wire logic        penable_in,
    input wire logic        pwrite_in,
    input wire logic [7:0]  paddr_in,
    input wire logic [31:0] pwdata_in,
    input wire logic [31:0] prdata_out,
    input wire logic        pready_out,
    input wire logic        pslverr_out,
    input wire logic        sw_irq_out,
    input wire logic        sw_rst_req_out,
    input wire logic        hw_irq_out,
    input wire logic        hw_rst_req_out
);
    // ------------------------------------------------------------
    // Single clock domain
    // ------------------------------------------------------------
    default clocking @(posedge core_clk_in); endclocking
    default disable iff (!nrst_in);

    // A bus write may clear or raise events, so holds exclude it.
    logic bus_wr;
    assign bus_wr = psel_in && penable_in && pwrite_in;

    sw_escalate_a: assert property ($rose(sw_rst_req_out) |-> $past(sw_irq_out))
        else $error("software reset request without pending interrupt");
    hw_escalate_a: assert property ($rose(hw_rst_req_out) |-> $past(hw_irq_out))
        else $error("autonomous reset request without pending interrupt");
    sw_sticky_a: assert property (sw_rst_req_out && !soft_reset_in |=> sw_rst_req_out)
        else $error("software reset request dropped");
    hw_sticky_a: assert property (hw_rst_req_out |=> hw_rst_req_out)
        else $error("autonomous reset request dropped");
    soft_stop_a: assert property (soft_reset_in |=> !sw_irq_out && !sw_rst_req_out)
        else $error("software watchdog survived a software reset");
    irq_hold_a: assert property (sw_irq_out && !soft_reset_in && !bus_wr |=> sw_irq_out)
        else $error("software interrupt dropped without a kick");
    halt_pause_a: assert property (
        $past(pclk_halt_in) && $past(pclk_halt_in, 2) && $past(pclk_halt_in, 3)
        && !$past(psel_in) && !$past(psel_in, 2) |-> !$rose(sw_irq_out))
        else $error("software watchdog advanced while halted");
    slow_pause_a: assert property (!slow_rc_clock_in [*8] |=> !$rose(hw_irq_out))
        else $error("autonomous watchdog advanced with its clock stopped");
    rdata_hold_a: assert property (
        $changed(prdata_out) |-> $past(psel_in && !penable_in && !pwrite_in))
        else $error("read data changed outside a read setup phase");
endmodule

bind dwdt_top dwdt_props #(.SW_DIV(SW_DIV)) i_props (
    .core_clk_in, .nrst_in, .soft_reset_in, .pclk_halt_in, .slow_rc_clock_in,
    .psel_in, .penable_in, .pwrite_in, .paddr_in, .pwdata_in, .prdata_out,
    .pready_out, .pslverr_out, .sw_irq_out, .sw_rst_req_out, .hw_irq_out,
    .hw_rst_req_out
);
`default_nettype wire

// >>> dv/tb_top.sv
// Self-checking bench for the dual watchdog timer.
`timescale 1ns/100ps
`default_nettype none

module tb_top;
    logic        clk, nrst, soft_rst, halt, slow, slow_run, rd_err;
    logic        psel, penable, pwrite, pready, pslverr;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd_q, v;
    wire  [3:0]  outs;
    int          error_cnt = 0;
    int          compares = 0;

    // Count clock of 1 keeps decrements exact per bus cycle.
    dwdt_top #(.SW_DIV(1)) i_dut (
        .core_clk_in(clk), .nrst_in(nrst), .soft_reset_in(soft_rst),
        .pclk_halt_in(halt), .slow_rc_clock_in(slow), .psel_in(psel),
        .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr),
        .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready),
        .pslverr_out(pslverr), .sw_irq_out(outs[0]), .sw_rst_req_out(outs[1]),
        .hw_irq_out(outs[2]), .hw_rst_req_out(outs[3])
    );
    dwdt_apb_host i_host (
        .clk_in(clk), .prdata_in(prdata), .pready_in(pready), .pslverr_in(pslverr),
        .psel_out(psel), .penable_out(penable), .pwrite_out(pwrite),
        .paddr_out(paddr), .pwdata_out(pwdata)
    );

    // Bus clock, and a slow oscillator of eight bus cycles, moved off the sampling edge.
    always #20 clk = ~clk;
    always begin
        repeat (4) @(negedge clk);
        slow = slow_run & ~slow;
    end

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic give_verdict();
        $display("compares %0d error_cnt %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic chk1(input logic got, input logic exp);
        chk32({31'h0, got}, {31'h0, exp});
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        i_host.xfer(1'b1, a, d, rd_q, rd_err);
    endtask
    task automatic rd(input logic [7:0] a);
        i_host.xfer(1'b0, a, 32'h00000000, rd_q, rd_err);
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
        rd(a);
        chk32(rd_q, exp);
    endtask
    // Waits for one event output; running out counts as a mismatch.
    task automatic wait_out(input int b, input int n);
        for (int i = 0; i < n; i++) begin
            @(negedge clk);
            if (outs[b] === 1'b1) return;
        end
        error_cnt++;
        $display("ERROR %0t: event wait ran out", $time);
        give_verdict();
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_reset_vals();
        rdchk(dwdt_pkg::SW_LOAD_OFS, dwdt_pkg::SW_LOAD_RST);
        rdchk(dwdt_pkg::SW_VALUE_OFS, dwdt_pkg::SW_LOAD_RST);
        rdchk(dwdt_pkg::HW_LOAD_OFS, dwdt_pkg::HW_LOAD_RST);
        rdchk(dwdt_pkg::SW_CTRL_OFS, 32'h00000000);
        rdchk(dwdt_pkg::HW_CTRL_OFS, 32'h00000003);
        rdchk(8'h3C, 32'h00000000);
        chk1(rd_err, 1'b1);
    endtask
    task automatic t_sw_run();
        wr(dwdt_pkg::SW_LOAD_OFS, 32'h00000030);
        wr(dwdt_pkg::SW_CTRL_OFS, 32'h00000003);
        rd(dwdt_pkg::SW_VALUE_OFS);
        v = rd_q;
        chk1(v <= 32'h30 && v > 32'h28, 1'b1);
        rdchk(dwdt_pkg::SW_VALUE_OFS, v - 32'h3);
        wait_out(0, 120);
        chk1(outs[1], 1'b0);
        rdchk(dwdt_pkg::SW_RAW_OFS, 32'h00000001);
        wr(dwdt_pkg::SW_KICK_OFS, 32'h0000005A);
        chk1(outs[0], 1'b0);
        wait_out(0, 120);
        wait_out(1, 120);
        @(negedge clk) soft_rst = 1'b1;
        @(negedge clk) soft_rst = 1'b0;
        chk1(outs[1], 1'b0);
        rdchk(dwdt_pkg::SW_CTRL_OFS, 32'h00000000);
    endtask
    task automatic t_lock();
        wr(dwdt_pkg::SW_GUARD_OFS, 32'h00000000);
        wr(dwdt_pkg::SW_LOAD_OFS, 32'h00000055);
        rdchk(dwdt_pkg::SW_LOAD_OFS, dwdt_pkg::SW_LOAD_RST);
        wr(dwdt_pkg::SW_GUARD_OFS, dwdt_pkg::UNLOCK_KEY);
        wr(dwdt_pkg::SW_KICK_OFS, 32'h00000000);
        rd(dwdt_pkg::SW_GUARD_OFS);
        chk1(rd_q[0], 1'b0);
    endtask
    task automatic t_irq_only_halt();
        wr(dwdt_pkg::SW_LOAD_OFS, 32'h00000010);
        wr(dwdt_pkg::SW_CTRL_OFS, 32'h00000001);
        wait_out(0, 60);
        repeat (60) @(negedge clk);
        chk1(outs[1], 1'b0);
        wr(dwdt_pkg::SW_KICK_OFS, 32'h00000000);
        halt = 1'b1;
        rd(dwdt_pkg::SW_VALUE_OFS);
        v = rd_q;
        repeat (6) @(negedge clk);
        rdchk(dwdt_pkg::SW_VALUE_OFS, v);
        halt = 1'b0;
        wr(dwdt_pkg::SW_CTRL_OFS, 32'h00000000);
        rd(dwdt_pkg::SW_VALUE_OFS);
        v = rd_q;
        rdchk(dwdt_pkg::SW_VALUE_OFS, v);
    endtask
    task automatic t_window();
        wr(dwdt_pkg::SW_WIN_OFS, 32'h00000008);
        rdchk(dwdt_pkg::SW_WIN_OFS, 32'h00000008);
        @(negedge clk) soft_rst = 1'b1;
        @(negedge clk) soft_rst = 1'b0;
        wr(dwdt_pkg::SW_WIN_OFS, 32'h00000008);
        wr(dwdt_pkg::SW_LOAD_OFS, 32'h00000040);
        wr(dwdt_pkg::SW_CTRL_OFS, 32'h00000005);
        wr(dwdt_pkg::SW_KICK_OFS, 32'h00000000);
        chk1(outs[0], 1'b1);
    endtask
    task automatic t_hw();
        slow_run = 1'b1;
        wr(dwdt_pkg::HW_LOAD_OFS, 32'h00000004);
        rdchk(dwdt_pkg::HW_LOAD_OFS, dwdt_pkg::HW_LOAD_RST);
        wr(dwdt_pkg::HW_GUARD_OFS, dwdt_pkg::UNLOCK_KEY);
        wr(dwdt_pkg::HW_LOAD_OFS, 32'h00000004);
        rdchk(dwdt_pkg::HW_LOAD_OFS, 32'h00000004);
        wait_out(2, 200);
        wr(dwdt_pkg::HW_GUARD_OFS, dwdt_pkg::UNLOCK_KEY);
        wr(dwdt_pkg::HW_KICK_OFS, 32'h0000003C);
        wr(dwdt_pkg::HW_KICK_OFS, 32'h000000C3);
        chk1(outs[2], 1'b0);
        rd(dwdt_pkg::HW_GUARD_OFS);
        chk1(rd_q[0], 1'b1);
        wait_out(2, 200);
        wr(dwdt_pkg::HW_GUARD_OFS, dwdt_pkg::UNLOCK_KEY);
        wr(dwdt_pkg::HW_KICK_OFS, 32'h00000011);
        wr(dwdt_pkg::HW_KICK_OFS, 32'h00000022);
        chk1(outs[2], 1'b1);
        wait_out(3, 200);
        wr(dwdt_pkg::HW_GUARD_OFS, dwdt_pkg::UNLOCK_KEY);
        wr(dwdt_pkg::HW_CTRL_OFS, 32'h00000000);
        rdchk(dwdt_pkg::HW_CTRL_OFS, 32'h00000003);
        wr(dwdt_pkg::HW_GUARD_OFS, dwdt_pkg::UNLOCK_KEY);
        wr(dwdt_pkg::HW_GUARD_OFS, dwdt_pkg::CTRL_KEY);
        wr(dwdt_pkg::HW_CTRL_OFS, 32'h00000000);
        rdchk(dwdt_pkg::HW_CTRL_OFS, 32'h00000000);
        slow_run = 1'b0;
        repeat (20) @(negedge clk);
    endtask

    // Reset for five cycles, then every scenario in turn.
    initial begin
        clk = 1'b0;
        nrst = 1'b0;
        soft_rst = 1'b0;
        halt = 1'b0;
        slow = 1'b0;
        slow_run = 1'b0;
        repeat (5) @(negedge clk);
        nrst = 1'b1;
        t_reset_vals();
        t_sw_run();
        t_lock();
        t_irq_only_halt();
        t_window();
        t_hw();
        give_verdict();
    end
endmodule
`default_nettype wire

// >>> verilog/dwdt_pkg.sv
// Shared constants and types for the dual watchdog timer block.
package dwdt_pkg;

    // ------------------------------------------------------------------
    // Register byte offsets on the peripheral bus
    // ------------------------------------------------------------------
    localparam logic [7:0] SW_LOAD_OFS   = 8'h00;
    localparam logic [7:0] SW_VALUE_OFS  = 8'h04;
    localparam logic [7:0] SW_CTRL_OFS   = 8'h08;
    localparam logic [7:0] SW_KICK_OFS   = 8'h0C;
    localparam logic [7:0] SW_RAW_OFS    = 8'h10;
    localparam logic [7:0] SW_WIN_OFS    = 8'h14;
    localparam logic [7:0] SW_GUARD_OFS  = 8'h18;
    localparam logic [7:0] HW_LOAD_OFS   = 8'h40;
    localparam logic [7:0] HW_VALUE_OFS  = 8'h44;
    localparam logic [7:0] HW_CTRL_OFS   = 8'h48;
    localparam logic [7:0] HW_KICK_OFS   = 8'h4C;
    localparam logic [7:0] HW_RAW_OFS    = 8'h50;
    localparam logic [7:0] HW_GUARD_OFS  = 8'h58;

    // ------------------------------------------------------------------
    // Keys and reset values
    // ------------------------------------------------------------------
    localparam logic [31:0] UNLOCK_KEY    = 32'h1ACCE551;
    localparam logic [31:0] CTRL_KEY      = 32'hE5331AAE;
    localparam logic [31:0] SW_LOAD_RST   = 32'h0FFFFFFF;
    localparam logic [31:0] HW_LOAD_RST   = 32'h0000FFFF;
    localparam logic [31:0] SW_WIN_RST    = 32'h00000000;
    localparam logic [31:0] ZERO_WORD     = 32'h00000000;
    localparam logic [7:0]  KICK_MASK     = 8'hFF;

    // Default division of the bus clock that makes the software count clock.
    localparam int          SW_DIV_DEFAULT = 4;
    localparam int          SW_DIV_MAX     = 256;

    // ------------------------------------------------------------------
    // Field layout of both control registers, bits 2:0
    // ------------------------------------------------------------------
    typedef struct packed {
        logic win_en;   // Bit 2: window mode, software watchdog only.
        logic rst_en;   // Bit 1: reset request on second underflow or window violation.
        logic irq_en;   // Bit 0: interrupt enable, also the run bit.
    } dwdt_ctrl_t;

    localparam dwdt_ctrl_t SW_CTRL_RST = 3'h0;
    localparam dwdt_ctrl_t HW_CTRL_RST = 3'h3;

    // Lock states of the autonomous watchdog.
    typedef enum logic [1:0] {
        HW_LOCKED,
        HW_OPEN,
        HW_OPEN_ALL
    } dwdt_hw_lock_t;

endpackage

// >>> verilog/dwdt_top.sv
// Dual watchdog timer: software watchdog and autonomous watchdog behind an APB slave.
`timescale 1ns/100ps
`default_nettype none

module dwdt_top #(
    parameter int SW_DIV = dwdt_pkg::SW_DIV_DEFAULT
) (
    input  wire logic        core_clk_in,
    input  wire logic        nrst_in,
    input  wire logic        soft_reset_in,
    input  wire logic        pclk_halt_in,
    input  wire logic        slow_rc_clock_in,
    input  wire logic        psel_in,
    input  wire logic        penable_in,
    input  wire logic        pwrite_in,
    input  wire logic [7:0]  paddr_in,
    input  wire logic [31:0] pwdata_in,
    output logic      [31:0] prdata_out,
    output logic             pready_out,
    output logic             pslverr_out,
    output logic             sw_irq_out,
    output logic             sw_rst_req_out,
    output logic             hw_irq_out,
    output logic             hw_rst_req_out
);

    // ------------------------------------------------------------------
    // Elaboration checks
    // ------------------------------------------------------------------
    if (SW_DIV < 1 || SW_DIV > dwdt_pkg::SW_DIV_MAX) begin : g_div_check
        $error("SW_DIV must lie between 1 and 256");
    end

    // ------------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------------

    // True for every offset that holds a register.
    function automatic logic ofs_known(input logic [7:0] a);
        unique case (a)
            dwdt_pkg::SW_LOAD_OFS, dwdt_pkg::SW_VALUE_OFS, dwdt_pkg::SW_CTRL_OFS,
            dwdt_pkg::SW_KICK_OFS, dwdt_pkg::SW_RAW_OFS, dwdt_pkg::SW_WIN_OFS,
            dwdt_pkg::SW_GUARD_OFS, dwdt_pkg::HW_LOAD_OFS, dwdt_pkg::HW_VALUE_OFS,
            dwdt_pkg::HW_CTRL_OFS, dwdt_pkg::HW_KICK_OFS, dwdt_pkg::HW_RAW_OFS,
            dwdt_pkg::HW_GUARD_OFS: ofs_known = 1'b1;
            default:                ofs_known = 1'b0;
        endcase
    endfunction
    logic bus_wr;
    logic bus_rd_setup;
    // Writes land in the access phase; reads are fetched in the setup phase.
    assign bus_wr       = psel_in & penable_in & pwrite_in;
    assign bus_rd_setup = psel_in & ~penable_in & ~pwrite_in;
    assign pready_out   = 1'b1;
    assign pslverr_out  = psel_in & penable_in & ~ofs_known(paddr_in);
    // Write strobe for one offset.
    function automatic logic wr_at(input logic wr, input logic [7:0] a, input logic [7:0] ofs);
        wr_at = wr & (a == ofs);
    endfunction

    // ------------------------------------------------------------------
    // Software watchdog registers
    // ------------------------------------------------------------------
    logic                 sw_reset;
    logic                 sw_unlocked_r;
    logic [31:0]          sw_interval_load_r;
    logic [31:0]          sw_window_control_r;
    dwdt_pkg::dwdt_ctrl_t sw_control_r;
    logic [31:0]          sw_count_r;
    logic                 sw_raw_irq_r;
    logic                 sw_rst_req_r;
    logic [7:0]           sw_div_r;
    logic                 sw_tick;
    logic                 sw_load_wr;
    logic                 sw_ctrl_wr;
    logic                 sw_kick_wr;
    logic                 sw_start;
    logic                 sw_reload;
    logic                 sw_underflow;
    logic                 sw_violation;
    logic                 sw_event;
    // A soft reset reaches the software watchdog but not the autonomous one.
    // any reset stops
    assign sw_reset = ~nrst_in | soft_reset_in;
    // Guard: key opens, anything else closes; kicks leave it as it is.
    // unlocked after reset
    always_ff @(posedge core_clk_in) begin
        if (sw_reset) begin
            sw_unlocked_r <= 1'b1;
        end else if (wr_at(bus_wr, paddr_in, dwdt_pkg::SW_GUARD_OFS)) begin
            sw_unlocked_r <= (pwdata_in == dwdt_pkg::UNLOCK_KEY); // key unlocks
        end
    end
    assign sw_load_wr = wr_at(bus_wr, paddr_in, dwdt_pkg::SW_LOAD_OFS) & sw_unlocked_r;
    assign sw_ctrl_wr = wr_at(bus_wr, paddr_in, dwdt_pkg::SW_CTRL_OFS) & sw_unlocked_r;
    assign sw_kick_wr = wr_at(bus_wr, paddr_in, dwdt_pkg::SW_KICK_OFS) & sw_unlocked_r;
    assign sw_start = sw_ctrl_wr & pwdata_in[0] & ~sw_control_r.irq_en;
    // Interval, window trigger and control registers.
    // interval register reset
    always_ff @(posedge core_clk_in) begin
        if (sw_reset) begin
            sw_interval_load_r  <= dwdt_pkg::SW_LOAD_RST;
            sw_window_control_r <= dwdt_pkg::SW_WIN_RST;
            sw_control_r        <= dwdt_pkg::SW_CTRL_RST;
        end else begin
            if (sw_load_wr) begin
                sw_interval_load_r <= pwdata_in;
            end
            if (wr_at(bus_wr, paddr_in, dwdt_pkg::SW_WIN_OFS) & sw_unlocked_r) begin
                sw_window_control_r <= pwdata_in;
            end
            if (sw_ctrl_wr) begin
                sw_control_r <= dwdt_pkg::dwdt_ctrl_t'(pwdata_in[2:0]); // zero stops
            end
        end
    end
    // Prescaler runs only while enabled and while the bus clock is up, so a
    // standby keeps both the prescaler phase and the count.
    // divided count clock
    always_ff @(posedge core_clk_in) begin
        if (sw_reset || sw_start || !sw_control_r.irq_en) begin
            sw_div_r <= 8'h00;
        end else if (!pclk_halt_in) begin
            sw_div_r <= sw_tick ? 8'h00 : sw_div_r + 8'h01;
        end
    end
    assign sw_tick = sw_control_r.irq_en & ~pclk_halt_in & (sw_div_r == 8'(SW_DIV - 1));

    assign sw_reload    = sw_kick_wr | sw_load_wr | sw_start;
    assign sw_underflow = sw_tick & (sw_count_r == dwdt_pkg::ZERO_WORD) & ~sw_reload;
    // An early kick or interval write counts as a failure in window mode.
    // window violation
    assign sw_violation = sw_control_r.win_en & sw_control_r.irq_en
                        & (sw_kick_wr | sw_load_wr) & (sw_count_r > sw_window_control_r);
    assign sw_event     = sw_underflow | sw_violation;
    // Down counter; a reload writes the new interval straight through.
    // 32-bit down counter
    always_ff @(posedge core_clk_in) begin
        if (sw_reset) begin
            sw_count_r <= dwdt_pkg::SW_LOAD_RST;
        end else if (sw_reload) begin
            sw_count_r <= sw_load_wr ? pwdata_in : sw_interval_load_r;
        end else if (sw_tick) begin
            sw_count_r <= (sw_count_r == dwdt_pkg::ZERO_WORD) ? sw_interval_load_r
                                                               : sw_count_r - 32'h00000001;
        end
    end
    // Event escalation: the event wins over a kick in the same cycle.
    // interrupt then reset
    always_ff @(posedge core_clk_in) begin
        if (sw_reset) begin
            sw_raw_irq_r <= 1'b0;
            sw_rst_req_r <= 1'b0;
        end else if (sw_event) begin
            sw_raw_irq_r <= 1'b1;
            if (sw_raw_irq_r && sw_control_r.rst_en) begin
                sw_rst_req_r <= 1'b1;
            end
        end else if (sw_kick_wr) begin
            sw_raw_irq_r <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Autonomous watchdog
    // ------------------------------------------------------------------
    logic                    slow_meta_r;
    logic                    slow_sync_r;
    logic                    slow_prev_r;
    logic                    hw_tick;
    dwdt_pkg::dwdt_hw_lock_t hw_lock_r;
    logic [31:0]             hw_interval_load_r;
    dwdt_pkg::dwdt_ctrl_t    hw_control_r;
    logic [31:0]             hw_count_r;
    logic                    hw_raw_irq_r;
    logic                    hw_rst_req_r;
    logic                    hw_kick_armed_r;
    logic [7:0]              hw_kick_byte_r;
    logic                    hw_open;
    logic                    hw_load_wr;
    logic                    hw_ctrl_wr;
    logic                    hw_kick_wr;
    logic                    hw_kick_done;
    logic                    hw_start;
    logic                    hw_reload;
    logic                    hw_underflow;
    // The oscillator is sampled through two flops; its rising edge is the
    // count enable, so a stopped oscillator simply produces no enables.
    // two-flop synchroniser
    always_ff @(posedge core_clk_in) begin
        if (!nrst_in) begin
            slow_meta_r <= 1'b0;
            slow_sync_r <= 1'b0;
            slow_prev_r <= 1'b0;
        end else begin
            slow_meta_r <= slow_rc_clock_in;
            slow_sync_r <= slow_meta_r;
            slow_prev_r <= slow_sync_r;
        end
    end
    assign hw_tick = hw_control_r.irq_en & slow_sync_r & ~slow_prev_r;

    assign hw_open    = (hw_lock_r != dwdt_pkg::HW_LOCKED);
    assign hw_load_wr = wr_at(bus_wr, paddr_in, dwdt_pkg::HW_LOAD_OFS) & hw_open;
    assign hw_kick_wr = wr_at(bus_wr, paddr_in, dwdt_pkg::HW_KICK_OFS) & hw_open;
    assign hw_ctrl_wr = wr_at(bus_wr, paddr_in, dwdt_pkg::HW_CTRL_OFS)
                      & (hw_lock_r == dwdt_pkg::HW_OPEN_ALL);
    assign hw_kick_done = hw_kick_wr & hw_kick_armed_r
                        & (pwdata_in[7:0] == (hw_kick_byte_r ^ dwdt_pkg::KICK_MASK));
    // Lock sequencer; a load or control write or a finished kick closes it again.
    // second key opens control
    always_ff @(posedge core_clk_in) begin
        if (!nrst_in) begin
            hw_lock_r <= dwdt_pkg::HW_LOCKED;
        end else if (wr_at(bus_wr, paddr_in, dwdt_pkg::HW_GUARD_OFS)) begin
            if (pwdata_in == dwdt_pkg::UNLOCK_KEY) begin
                hw_lock_r <= dwdt_pkg::HW_OPEN;
            end else if (pwdata_in == dwdt_pkg::CTRL_KEY && hw_lock_r == dwdt_pkg::HW_OPEN) begin
                hw_lock_r <= dwdt_pkg::HW_OPEN_ALL;
            end else begin
                hw_lock_r <= dwdt_pkg::HW_LOCKED;
            end
        end else if (hw_load_wr || hw_ctrl_wr || hw_kick_done) begin
            hw_lock_r <= dwdt_pkg::HW_LOCKED;
        end
    end
    // Two-write kick: a mismatched second byte drops the pair.
    always_ff @(posedge core_clk_in) begin
        if (!nrst_in) begin
            hw_kick_armed_r <= 1'b0;
            hw_kick_byte_r  <= 8'h00;
        end else if (hw_kick_wr) begin
            hw_kick_armed_r <= ~hw_kick_armed_r;
            hw_kick_byte_r  <= pwdata_in[7:0];
        end
    end

    assign hw_start = hw_ctrl_wr & pwdata_in[0] & ~hw_control_r.irq_en;
    // Control resets to running with reset escalation, so no software is
    // needed to arm it; a soft reset is deliberately not looked at here.
    // runs after reset
    always_ff @(posedge core_clk_in) begin
        if (!nrst_in) begin
            hw_interval_load_r <= dwdt_pkg::HW_LOAD_RST;
            hw_control_r       <= dwdt_pkg::HW_CTRL_RST;
        end else begin
            if (hw_load_wr) begin
                hw_interval_load_r <= pwdata_in;
            end
            if (hw_ctrl_wr) begin
                hw_control_r <= dwdt_pkg::dwdt_ctrl_t'({1'b0, pwdata_in[1:0]});
            end
        end
    end

    assign hw_reload    = hw_kick_done | hw_load_wr | hw_start;
    assign hw_underflow = hw_tick & (hw_count_r == dwdt_pkg::ZERO_WORD) & ~hw_reload;

    always_ff @(posedge core_clk_in) begin
        if (!nrst_in) begin
            hw_count_r <= dwdt_pkg::HW_LOAD_RST;
        end else if (hw_reload) begin
            hw_count_r <= hw_load_wr ? pwdata_in : hw_interval_load_r;
        end else if (hw_tick) begin
            hw_count_r <= (hw_count_r == dwdt_pkg::ZERO_WORD) ? hw_interval_load_r
                                                               : hw_count_r - 32'h00000001;
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (!nrst_in) begin
            hw_raw_irq_r <= 1'b0;
            hw_rst_req_r <= 1'b0;
        end else if (hw_underflow) begin
            hw_raw_irq_r <= 1'b1;
            if (hw_raw_irq_r && hw_control_r.rst_en) begin
                hw_rst_req_r <= 1'b1;
            end
        end else if (hw_kick_done) begin
            hw_raw_irq_r <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Read data and request outputs
    // ------------------------------------------------------------------

    // Read data is captured in the setup phase so it is a flop output in the
    // access phase; the counter may move by one tick in between.
    // live counter readback
    always_ff @(posedge core_clk_in) begin
        if (!nrst_in) begin
            prdata_out <= dwdt_pkg::ZERO_WORD;
        end else if (bus_rd_setup) begin
            unique case (paddr_in)
                dwdt_pkg::SW_LOAD_OFS:  prdata_out <= sw_interval_load_r;
                dwdt_pkg::SW_VALUE_OFS: prdata_out <= sw_count_r;
                dwdt_pkg::SW_CTRL_OFS:  prdata_out <= {29'h0, sw_control_r};
                dwdt_pkg::SW_RAW_OFS:   prdata_out <= {31'h0, sw_raw_irq_r};
                dwdt_pkg::SW_WIN_OFS:   prdata_out <= sw_window_control_r;
                dwdt_pkg::SW_GUARD_OFS: prdata_out <= {31'h0, ~sw_unlocked_r};
                dwdt_pkg::HW_LOAD_OFS:  prdata_out <= hw_interval_load_r;
                dwdt_pkg::HW_VALUE_OFS: prdata_out <= hw_count_r;
                dwdt_pkg::HW_CTRL_OFS:  prdata_out <= {29'h0, hw_control_r};
                dwdt_pkg::HW_RAW_OFS:   prdata_out <= {31'h0, hw_raw_irq_r};
                dwdt_pkg::HW_GUARD_OFS: prdata_out <= {30'h0,
                                                       hw_lock_r == dwdt_pkg::HW_OPEN_ALL,
                                                       hw_lock_r == dwdt_pkg::HW_LOCKED};
                default:                prdata_out <= dwdt_pkg::ZERO_WORD;
            endcase
        end
    end
    // Requests are sticky levels; the reset controller answers with a reset.
    assign sw_irq_out     = sw_raw_irq_r;
    assign sw_rst_req_out = sw_rst_req_r;
    assign hw_irq_out     = hw_raw_irq_r;
    assign hw_rst_req_out = hw_rst_req_r;

endmodule

`default_nettype wire
